// ===== hw/umpc_core.sv
// Modem control and status pins, mode strap and terminal count
//
// Summary of operation
// - Mode pin low is PC, else standard
// - PC: select input; standard: output from bit3
// - Low clear-to-send is ready; status bit4
// - Clear-to-send gates data only with ENHANCED_FEATURE_REG bit7
// - Data-set-ready reported only, no data effect
// - Terminal-ready low when control bit0 set
// - Ring indicator rising edge raises interrupt
// - Request-to-send low when control bit1 set
// - Request-to-send gates data only with bit6
// - Low carrier detect means carrier present
// - Control bit6 picks infrared, idle low receive
// - Transmit idles high standard, low infrared
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "umpc_map.svh"

module umpc_core
   import umpc_pkg::*;
(
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   input  wire logic [`UMPC_ADDR_W-1:0] addr,
   input  wire logic [7:0]             wdata,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [7:0]             rdata,
   input  wire logic                   mode_sel_in,
   input  wire logic                   port_select_three_in,
   output logic                        user_output_two_out,
   output logic                        user_output_two_oe,
   output logic                        port_select_three,
   input  wire umpc_modem_t            modem_in,
   input  wire logic                   dma_count_done,
   output logic                        dma_done_pulse,
   input  wire logic                   serial_receive_in,
   output logic                        rx_data,
   input  wire logic                   tx_data,
   input  wire logic                   tx_active,
   output logic                        serial_tx_out,
   output logic                        terminal_ready_n,
   output logic                        request_to_send_n,
   output logic                        tx_allowed,
   output logic                        rx_flow_hold,
   input  wire logic                   rx_nearly_full,
   output logic                        modem_event
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Three stages; a change counts once stages two and three agree
   logic [6:0] s1_q;
   logic [6:0] s2_q;
   logic [6:0] s3_q;
   logic [6:0] stable_q;
   logic [6:0] raw;

   assign raw = {modem_in, mode_sel_in, port_select_three_in,
                 serial_receive_in};

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         s1_q     <= 7'h7F;
         s2_q     <= 7'h7F;
         s3_q     <= 7'h7F;
         stable_q <= 7'h7F;
      end
      else
      begin
         s1_q     <= raw;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         stable_q <= (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));
      end
   end

   umpc_modem_t modem_s;
   logic        mode_s;
   logic        s3_s;
   logic        rx_s;

   assign modem_s = umpc_modem_t'(stable_q[6:3]);
   assign mode_s  = stable_q[2];
   assign s3_s    = stable_q[1];
   assign rx_s    = stable_q[0];

   // Terminal count also enters through the same style of stages
   logic [2:0] tc_q;
   logic       tc_stable_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tc_q        <= 3'h0;
         tc_stable_q <= 1'b0;
      end
      else
      begin
         tc_q <= {tc_q[1:0], dma_count_done};
         if (tc_q[1] == tc_q[2])
            tc_stable_q <= tc_q[2];
      end
   end

   // Rising edge of the count marks one completed transfer
   logic tc_prev_q;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tc_prev_q      <= 1'b0;
         dma_done_pulse <= 1'b0;
      end
      else
      begin
         tc_prev_q      <= tc_stable_q;
         dma_done_pulse <= tc_stable_q & ~tc_prev_q;
      end
   end

   // ----------------------------------------------------------------
   // Mode strap
   // ----------------------------------------------------------------
   // Caught after reset release from the synchronised pin; the window
   // outlasts the synchroniser, so the settled pin level is the one kept
   umpc_mode_t mode_q;
   logic [2:0] strap_cnt_q;
   logic       strap_done;

   assign strap_done = (strap_cnt_q == `UMPC_STRAP_CYC);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_q      <= UMPC_STD;
         strap_cnt_q <= 3'h0;
      end
      else if (!strap_done)
      begin
         strap_cnt_q <= strap_cnt_q + 3'h1;
         mode_q      <= mode_s ? UMPC_STD : UMPC_PC;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [7:0] mcr_q;
   logic [7:0] efr_q;
   logic [3:0] delta_q;
   umpc_modem_t prev_q;
   logic       wr_mcr;
   logic       wr_efr;
   logic       rd_msr;

   assign wr_mcr = wr_en && (addr == `UMPC_OFF_MCR);
   assign wr_efr = wr_en && (addr == `UMPC_OFF_EFR);
   assign rd_msr = rd_en && (addr == `UMPC_OFF_MSR);

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         mcr_q <= `UMPC_MCR_RST;
      else if (wr_mcr)
         mcr_q <= wdata;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         efr_q <= `UMPC_EFR_RST;
      else if (wr_efr)
         efr_q <= wdata;
   end

   // Delta flags: a new edge beats the read that clears them
   logic [3:0] edge_set;

   assign edge_set[0] = modem_s.cts_n ^ prev_q.cts_n;
   assign edge_set[1] = modem_s.dsr_n ^ prev_q.dsr_n;
   assign edge_set[2] = modem_s.ri_n & ~prev_q.ri_n;
   assign edge_set[3] = modem_s.cd_n ^ prev_q.cd_n;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         prev_q  <= '1;
         delta_q <= 4'h0;
      end
      else
      begin
         prev_q  <= modem_s;
         delta_q <= (rd_msr ? 4'h0 : delta_q) | edge_set;
      end
   end

   assign modem_event = |delta_q;

   logic [7:0] modem_status_reg;

   always_comb
   begin
      modem_status_reg = 8'h00;
      modem_status_reg[`UMPC_MSR_DCTS] = delta_q[0];
      modem_status_reg[`UMPC_MSR_DDSR] = delta_q[1];
      modem_status_reg[`UMPC_MSR_TERI] = delta_q[2];
      modem_status_reg[`UMPC_MSR_DDCD] = delta_q[3];
      modem_status_reg[`UMPC_MSR_CTS]  = ~modem_s.cts_n;
      modem_status_reg[`UMPC_MSR_DSR]  = ~modem_s.dsr_n;
      modem_status_reg[`UMPC_MSR_RI]   = ~modem_s.ri_n;
      modem_status_reg[`UMPC_MSR_CD]   = ~modem_s.cd_n;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         rdata <= 8'h00;
      else if (rd_en)
      begin
         if (addr == `UMPC_OFF_MCR)
            rdata <= mcr_q;
         else if (addr == `UMPC_OFF_MSR)
            rdata <= modem_status_reg;
         else if (addr == `UMPC_OFF_EFR)
            rdata <= efr_q;
         else if (addr == `UMPC_OFF_PINS)
            rdata <= {6'h00, s3_s, mode_q == UMPC_STD};
         else
            rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Pin outputs
   // ----------------------------------------------------------------
   logic ir_mode;

   assign ir_mode = mcr_q[`UMPC_MCR_IR];

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         terminal_ready_n    <= 1'b1;
         request_to_send_n   <= 1'b1;
         user_output_two_out <= 1'b1;
         user_output_two_oe  <= 1'b0;
         port_select_three   <= 1'b1;
         serial_tx_out       <= 1'b1;
         rx_data             <= 1'b1;
      end
      else
      begin
         terminal_ready_n  <= ~mcr_q[`UMPC_MCR_DTR];
         request_to_send_n <= ~mcr_q[`UMPC_MCR_RTS];
         // Pin is an input in PC mode; wait for the strap so a PC board
         // never sees the pin driven right after reset
         user_output_two_oe  <= (mode_q == UMPC_STD) && strap_done;
         user_output_two_out <= ~mcr_q[`UMPC_MCR_OUT2];
         port_select_three   <= (mode_q == UMPC_PC) ? s3_s : 1'b1;
         // Idle level follows the interface choice
         serial_tx_out <= tx_active ? tx_data : ~ir_mode;
         // Infrared line idles low; present it as the usual high idle
         rx_data <= ir_mode ? ~rx_s : rx_s;
      end
   end

   // ----------------------------------------------------------------
   // Hardware flow control
   // ----------------------------------------------------------------
   // Without auto mode the modem lines never stall data
   assign tx_allowed = ~efr_q[`UMPC_EFR_ACTS] | ~modem_s.cts_n;
   assign rx_flow_hold = efr_q[`UMPC_EFR_ARTS] & rx_nearly_full;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   dtr_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
      wr_mcr |=> ##1 (terminal_ready_n == ~$past(wdata[0], 2)))
      else $error("terminal ready does not follow control bit");

   rts_follow_a: assert property (@(posedge clk) disable iff (!arst_n)
      wr_mcr |=> ##1 (request_to_send_n == ~$past(wdata[1], 2)))
      else $error("request to send does not follow control bit");

   cts_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      !efr_q[`UMPC_EFR_ACTS] |-> tx_allowed)
      else $error("clear to send gated without auto mode");

   cts_status_a: assert property (@(posedge clk) disable iff (!arst_n)
      modem_status_reg[`UMPC_MSR_CTS] == ~modem_s.cts_n)
      else $error("clear to send status wrong");

   ri_event_a: assert property (@(posedge clk) disable iff (!arst_n)
      (modem_s.ri_n && !prev_q.ri_n) |=> delta_q[2])
      else $error("ring edge lost");

   op2_drive_a: assert property (@(posedge clk) disable iff (!arst_n)
      (mode_q == UMPC_PC) |=> !user_output_two_oe)
      else $error("output two driven in PC mode");

   tx_idle_a: assert property (@(posedge clk) disable iff (!arst_n)
      !tx_active |=> (serial_tx_out == ~$past(ir_mode)))
      else $error("transmit idle level wrong");

   rts_gate_a: assert property (@(posedge clk) disable iff (!arst_n)
      !efr_q[`UMPC_EFR_ARTS] |-> !rx_flow_hold)
      else $error("request to send gated without auto mode");

   strap_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      strap_done |=> $stable(mode_q))
      else $error("mode strap changed after capture");

   pc_sel_a: assert property (@(posedge clk) disable iff (!arst_n)
      (mode_q == UMPC_STD) |=> port_select_three)
      else $error("select three not held high in standard mode");

   ir_rx_a: assert property (@(posedge clk) disable iff (!arst_n)
      (ir_mode && !rx_s) |=> rx_data)
      else $error("infrared idle receive not shown as high");

   dma_pulse_a: assert property (@(posedge clk) disable iff (!arst_n)
      dma_done_pulse |=> !dma_done_pulse)
      else $error("terminal count pulse longer than one cycle");

   ri_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
      edge_set[2] ##1 rd_msr);
   tc_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
      dma_done_pulse);
   ir_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
      ir_mode && tx_active);
   pc_cov_c: cover property (@(posedge clk) disable iff (!arst_n)
      (mode_q == UMPC_PC) && strap_done);

endmodule // umpc_core

// ===== hw/umpc_map.svh
// Register offsets, field positions, reset values and counts for umpc
`ifndef UMPC_MAP_SVH
`define UMPC_MAP_SVH
`define UMPC_ADDR_W         4
`define UMPC_OFF_MCR        4'h0
`define UMPC_OFF_MSR        4'h1
`define UMPC_OFF_EFR        4'h2
`define UMPC_OFF_PINS       4'h3
`define UMPC_MCR_DTR        0
`define UMPC_MCR_RTS        1
`define UMPC_MCR_OUT2       3
`define UMPC_MCR_IR         6
`define UMPC_MSR_DCTS       0
`define UMPC_MSR_DDSR       1
`define UMPC_MSR_TERI       2
`define UMPC_MSR_DDCD       3
`define UMPC_MSR_CTS        4
`define UMPC_MSR_DSR        5
`define UMPC_MSR_RI         6
`define UMPC_MSR_CD         7
`define UMPC_EFR_ARTS       6
`define UMPC_EFR_ACTS       7
`define UMPC_MCR_RST        8'h00
`define UMPC_EFR_RST        8'h00
`define UMPC_STRAP_CYC      3'h5
`endif

// ===== hw/umpc_pkg.sv
// Types shared by the modem pin control block
package umpc_pkg;
   typedef struct packed
   {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } umpc_modem_t;
   typedef enum logic {UMPC_PC, UMPC_STD} umpc_mode_t;
endpackage

// ===== tb/umpc_modem_model.sv
// Model of the modem and port select side of the pins
`timescale 1ns/1ps
module umpc_modem_model
   import umpc_pkg::*;
(
   input  wire logic clk,
   output umpc_modem_t modem,
   output logic        rx_line,
   output logic        dma_done,
   output logic        s3_val,
   output logic        s3_en
);
   // ----------------------------------------
   // Line drivers
   // ----------------------------------------
   // All lines start inactive; the select pin is left to its pull-up
   initial
   begin
      modem = '1;
      rx_line = 1'b1;
      dma_done = 1'b0;
      s3_val = 1'b1;
      s3_en = 1'b0;
   end
   task automatic set_lines(input logic [3:0] v);
      @(posedge clk);
      modem <= umpc_modem_t'(v);
   endtask
   // Idle level follows the interface chosen by the testbench
   task automatic set_rx(input logic v);
      @(posedge clk);
      rx_line <= v;
   endtask
   // High pulse of n cycles, then back low as when tied off
   task automatic pulse_done(input int n);
      @(posedge clk);
      dma_done <= 1'b1;
      repeat (n) @(posedge clk);
      dma_done <= 1'b0;
   endtask
   task automatic set_s3(input logic en, input logic v);
      @(posedge clk);
      s3_en <= en;
      s3_val <= v;
   endtask
endmodule // umpc_modem_model

// ===== tb/umpc_core_tb.sv
// Self-checking testbench for the modem pin control block
`timescale 1ns/1ps
module umpc_core_tb;
   localparam logic [3:0] A_CTL = 4'h0;
   localparam logic [3:0] A_ST = 4'h1;
   localparam logic [3:0] A_FE = 4'h2;
   localparam logic [3:0] A_PIN = 4'h3;
   logic clk = 1'b0;
   logic arst_n;
   logic mode_sel;
   logic [3:0] addr;
   logic [7:0] wdata;
   logic wr_en;
   logic rd_en;
   logic tx_data;
   logic tx_active;
   logic rx_full;
   logic [7:0] cnt;
   logic [7:0] rdata;
   logic op2_out, op2_oe, sel3, dma_pulse, rx_data, tx_out, dtr_n, rts_n;
   logic tx_ok, rx_hold, mod_ev, s3_pin, s3_val, s3_en, rx_line, dma_in;
   umpc_pkg::umpc_modem_t modem;
   int num_errors = 0;
   int num_checks = 0;
   // Shared pin: design drives in standard mode, else model or pull-up
   assign s3_pin = op2_oe ? op2_out : (s3_en ? s3_val : 1'b1);
   always #12.5 clk = ~clk;
   umpc_modem_model i_modem (.clk(clk), .modem(modem), .rx_line(rx_line),
      .dma_done(dma_in), .s3_val(s3_val), .s3_en(s3_en));
   umpc_core i_dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .mode_sel_in(mode_sel),
      .port_select_three_in(s3_pin), .user_output_two_out(op2_out),
      .user_output_two_oe(op2_oe), .port_select_three(sel3),
      .modem_in(modem), .dma_count_done(dma_in), .dma_done_pulse(dma_pulse),
      .serial_receive_in(rx_line), .rx_data(rx_data), .tx_data(tx_data),
      .tx_active(tx_active), .serial_tx_out(tx_out),
      .terminal_ready_n(dtr_n), .request_to_send_n(rts_n),
      .tx_allowed(tx_ok), .rx_flow_hold(rx_hold),
      .rx_nearly_full(rx_full), .modem_event(mod_ev));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Returns just after the edge on which the pins settle
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(n, rdata, e);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #2_000_000;
      num_errors++;
      end_of_test();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial
   begin
      arst_n    <= 1'b0;
      mode_sel  <= 1'b1;
      addr      <= 4'h0;
      wdata     <= 8'h00;
      wr_en     <= 1'b0;
      rd_en     <= 1'b0;
      tx_data   <= 1'b1;
      tx_active <= 1'b0;
      rx_full   <= 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      // Output enable waits for the strap window to close
      tick(8);
      chk("dtr_n", dtr_n, 8'h01);
      chk("rts_n", rts_n, 8'h01);
      chk("tx_out", tx_out, 8'h01);
      chk("op2_oe", op2_oe, 8'h01);
      rd(A_CTL, 8'h00, "ctl");
      rd(A_FE, 8'h00, "feat");
      rd(A_ST, 8'h00, "stat");
      rd(A_PIN, 8'h03, "pins");
      $display("test reset done");
      wr(A_CTL, 8'h03);
      chk("dtr_n", dtr_n, 8'h00);
      chk("rts_n", rts_n, 8'h00);
      wr(A_CTL, 8'h0A);
      chk("dtr_n", dtr_n, 8'h01);
      chk("op2", s3_pin, 8'h00);
      chk("sel3", sel3, 8'h01);
      rd(A_CTL, 8'h0A, "ctl");
      rd(4'hF, 8'h00, "unmapped");
      wr(A_ST, 8'hFF);
      wr(A_CTL, 8'h00);
      chk("op2", s3_pin, 8'h01);
      chk("rts_n", rts_n, 8'h01);
      rd(A_ST, 8'h00, "stat ro");
      $display("test control done");
      i_modem.set_lines(4'b0100);
      tick(6);
      chk("event", mod_ev, 8'h01);
      rd(A_ST, 8'hBB, "stat");
      tick(1);
      chk("event", mod_ev, 8'h00);
      i_modem.set_lines(4'b0000);
      tick(6);
      rd(A_ST, 8'hF0, "ring low");
      i_modem.set_lines(4'b0100);
      tick(6);
      chk("event", mod_ev, 8'h01);
      rd(A_ST, 8'hB4, "ring end");
      $display("test status done");
      i_modem.set_lines(4'b0101);
      tick(6);
      chk("tx_ok", tx_ok, 8'h01);
      wr(A_FE, 8'h80);
      chk("tx_ok", tx_ok, 8'h00);
      i_modem.set_lines(4'b0110);
      tick(6);
      chk("tx_ok", tx_ok, 8'h01);
      @(posedge clk);
      rx_full <= 1'b1;
      wr(A_FE, 8'h40);
      chk("rx_hold", rx_hold, 8'h01);
      chk("tx_ok", tx_ok, 8'h01);
      wr(A_FE, 8'h00);
      chk("rx_hold", rx_hold, 8'h00);
      @(posedge clk);
      rx_full <= 1'b0;
      $display("test flow done");
      @(posedge clk);
      tx_active <= 1'b1;
      tx_data   <= 1'b0;
      tick(2);
      chk("tx_out", tx_out, 8'h00);
      @(posedge clk);
      tx_active <= 1'b0;
      tick(2);
      chk("tx_out", tx_out, 8'h01);
      chk("rx", rx_data, 8'h01);
      wr(A_CTL, 8'h40);
      chk("tx_out", tx_out, 8'h00);
      i_modem.set_rx(1'b0);
      tick(6);
      chk("rx", rx_data, 8'h01);
      i_modem.set_rx(1'b1);
      tick(6);
      chk("rx", rx_data, 8'h00);
      wr(A_CTL, 8'h00);
      $display("test serial done");
      cnt = 8'h00;
      fork
         i_modem.pulse_done(2);
      join_none
      repeat (10)
      begin
         tick(1);
         if (dma_pulse === 1'b1)
            cnt++;
      end
      chk("dma", cnt, 8'h01);
      $display("test dma done");
      // PC mode needs a fresh reset since the strap is latched once
      @(posedge clk);
      arst_n   <= 1'b0;
      mode_sel <= 1'b0;
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      tick(8);
      chk("op2_oe", op2_oe, 8'h00);
      rd(A_PIN, 8'h02, "pins");
      i_modem.set_s3(1'b1, 1'b0);
      tick(6);
      chk("sel3", sel3, 8'h00);
      rd(A_PIN, 8'h00, "pins");
      $display("test pc mode done");
      end_of_test();
   end
endmodule // umpc_core_tb
